/* safe_input_monitor.sv */
`timescale 1ns/100ps
module safe_input_monitor #(
  parameter int N_IN = 4,
  parameter int DISC_CYCLES = sosc_pkg::DISC_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N_IN-1:0] chan_a,
  input wire logic [N_IN-1:0] chan_b,
  safe_io_if.in_mon io
);
  localparam int CW = $clog2(DISC_CYCLES + 1);
  localparam logic [CW-1:0] DISC_LIMIT = CW'(DISC_CYCLES);

  logic [CW-1:0] disc_cnt [N_IN];
  logic [N_IN-1:0] level;
  logic [N_IN-1:0] edge_seen;
  logic fault;
  logic [N_IN-1:0] disc_hit;

  // ----------------------------------------------------------------
  // level and edge supervision per two-channel input
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N_IN; i++)
      disc_hit[i] = (disc_cnt[i] == DISC_LIMIT);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      level <= '0;
      edge_seen <= '0;
      fault <= 1'b0;
      for (int i = 0; i < N_IN; i++)
        disc_cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < N_IN; i++)
      begin
        if (chan_a[i] == chan_b[i])
          disc_cnt[i] <= '0;
        else if (!disc_hit[i])
          disc_cnt[i] <= disc_cnt[i] + CW'(1);
      end
      edge_seen <= (chan_a & (chan_a ~^ chan_b)) ^ (level & ~(chan_a ^ chan_b))
        & ~(chan_a ^ chan_b);
      level <= (chan_a & ~(chan_a ^ chan_b)) | (level & (chan_a ^ chan_b));
      // set wins over clear
      fault <= (fault & ~io.clear) | (|disc_hit);
    end
  end

  assign io.in_level = level;
  assign io.in_edge = edge_seen;
  assign io.in_fault = fault;
endmodule : safe_input_monitor

/* safe_io_if.sv */
`timescale 1ns/100ps
interface safe_io_if #(
  parameter int N_IN = 4,
  parameter int N_OUT = 2
);
  logic [N_IN-1:0] in_level;
  logic [N_IN-1:0] in_edge;
  logic in_fault;
  logic [N_OUT-1:0] out_cmd;
  logic out_fault;
  logic clear;

  modport in_mon (output in_level, output in_edge, output in_fault, input clear);
  modport out_chk (input out_cmd, output out_fault, input clear);
  modport ctrl (input in_level, input in_edge, input in_fault, output out_cmd,
    input out_fault, output clear);
endinterface : safe_io_if

/* safe_output_check.sv */
`timescale 1ns/100ps
module safe_output_check #(
  parameter int N_OUT = 2,
  parameter int TEST_PERIOD = sosc_pkg::TEST_PERIOD_CYCLES,
  parameter int TEST_WIDTH = sosc_pkg::TEST_WIDTH_CYCLES,
  parameter int SETTLE = sosc_pkg::SETTLE_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [N_OUT-1:0] readback,
  output logic [N_OUT-1:0] drive,
  safe_io_if.out_chk io
);
  localparam int PW = $clog2(TEST_PERIOD + 1);
  localparam int SW = $clog2(SETTLE + 1);
  localparam logic [PW-1:0] PERIOD_END = PW'(TEST_PERIOD - 1);
  localparam logic [PW-1:0] PULSE_START = PW'(TEST_PERIOD - TEST_WIDTH);
  localparam logic [SW-1:0] SETTLE_LIMIT = SW'(SETTLE);

  logic [PW-1:0] period_cnt;
  logic [SW-1:0] miss_cnt [N_OUT];
  logic [N_OUT-1:0] miss_hit;
  logic fault;
  wire test_pulse = (period_cnt >= PULSE_START);

  // ----------------------------------------------------------------
  // test pulses and readback comparison
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int i = 0; i < N_OUT; i++)
      miss_hit[i] = (miss_cnt[i] == SETTLE_LIMIT);
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      period_cnt <= '0;
      drive <= '0;
      fault <= 1'b0;
      for (int i = 0; i < N_OUT; i++)
        miss_cnt[i] <= '0;
    end
    else
    begin
      period_cnt <= (period_cnt == PERIOD_END) ? '0 : period_cnt + PW'(1);
      drive <= io.out_cmd & ~{N_OUT{test_pulse}};
      for (int i = 0; i < N_OUT; i++)
      begin
        if (readback[i] == drive[i])
          miss_cnt[i] <= '0;
        else if (!miss_hit[i])
          miss_cnt[i] <= miss_cnt[i] + SW'(1);
      end
      fault <= (fault & ~io.clear) | (|miss_hit);
    end
  end

  assign io.out_fault = fault;
endmodule : safe_output_check

/* safety_operating_state_controller.sv */
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
module safety_operating_state_controller #(
  parameter int N_IN = 4,
  parameter int N_OUT = 2,
  parameter int TEST_PERIOD_CYCLES = sosc_pkg::TEST_PERIOD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [sosc_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [N_IN-1:0] SAFE_IN_A,
  input wire logic [N_IN-1:0] SAFE_IN_B,
  output logic [N_OUT-1:0] SAFE_OUT,
  input wire logic [N_OUT-1:0] SAFE_OUT_READBACK,
  input wire logic [sosc_pkg::SF_COUNT-1:0] ACTIVE_FUNCTIONS,
  input wire logic LIMIT_VIOLATION,
  input wire logic FATAL_ERROR,
  input wire logic BRAKE_RAMP_EXCEEDED,
  input wire logic CFG_PRESENT,
  output logic SELF_TEST_START,
  input wire logic SELF_TEST_DONE,
  input wire logic SELF_TEST_FAULT,
  output logic TORQUE_OFF,
  output logic RAMPED_HALT_ACTIVE,
  output logic [2:0] OP_STATE,
  output logic [1:0] SUB_STATUS
);
  localparam int DW = sosc_pkg::DELAY_W;
  localparam int PSW = $clog2(sosc_pkg::US_CYCLES);
  localparam logic [PSW-1:0] US_END = PSW'(sosc_pkg::US_CYCLES - 1);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  if (N_IN < 2 || N_IN > 16)
  begin : g_bad_in
    $error("N_IN must lie between 2 and 16");
  end
  if (N_OUT < 1 || N_OUT > 32)
  begin : g_bad_out
    $error("N_OUT must lie between 1 and 32");
  end
  if (TEST_PERIOD_CYCLES <= sosc_pkg::TEST_WIDTH_CYCLES + sosc_pkg::SETTLE_CYCLES)
  begin : g_bad_period
    $error("TEST_PERIOD_CYCLES too short for test pulse and settle time");
  end

  // ----------------------------------------------------------------
  // input and output supervision
  // ----------------------------------------------------------------
  safe_io_if #(.N_IN(N_IN), .N_OUT(N_OUT)) sio ();

  safe_input_monitor #(
    .N_IN(N_IN),
    .DISC_CYCLES(sosc_pkg::DISC_CYCLES)
  ) u_in_mon (
    .clk(REF_CLK),
    .rst(RST),
    .chan_a(SAFE_IN_A),
    .chan_b(SAFE_IN_B),
    .io(sio.in_mon)
  );

  safe_output_check #(
    .N_OUT(N_OUT),
    .TEST_PERIOD(TEST_PERIOD_CYCLES),
    .TEST_WIDTH(sosc_pkg::TEST_WIDTH_CYCLES),
    .SETTLE(sosc_pkg::SETTLE_CYCLES)
  ) u_out_chk (
    .clk(REF_CLK),
    .rst(RST),
    .readback(SAFE_OUT_READBACK),
    .drive(SAFE_OUT),
    .io(sio.out_chk)
  );

  // ----------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------
  sosc_pkg::op_state_e state;
  sosc_pkg::op_state_e next_state;
  sosc_pkg::sub_status_e sub;
  sosc_pkg::sub_status_e next_sub;
  logic boot_pending;
  logic cfg_valid;
  logic cfg_req;
  logic brake_mon;
  logic [DW-1:0] halt_delay;
  logic [N_OUT-1:0] out_cmd;
  logic [DW-1:0] halt_left;
  logic [PSW-1:0] us_cnt;
  logic startup_begun;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire hit_ctrl = (PADDR == sosc_pkg::CTRL_OFS);
  wire hit_delay = (PADDR == sosc_pkg::DELAY_OFS);
  wire hit_outcmd = (PADDR == sosc_pkg::OUTCMD_OFS);
  wire hit_status = (PADDR == sosc_pkg::STATUS_OFS);
  wire addr_hit = hit_ctrl | hit_delay | hit_outcmd | hit_status;
  wire access = PSEL & PENABLE;
  wire wr_ok = access & PWRITE & addr_hit;
  wire wr_ctrl = wr_ok & hit_ctrl;
  wire reset_action = wr_ctrl & PWDATA[sosc_pkg::CTRL_RESET_BIT];
  wire cfg_req_set = wr_ctrl & PWDATA[sosc_pkg::CTRL_CFG_REQ_BIT];
  wire cfg_ok = wr_ctrl & PWDATA[sosc_pkg::CTRL_CFG_OK_BIT];
  wire cfg_bad = wr_ctrl & PWDATA[sosc_pkg::CTRL_CFG_BAD_BIT];

  wire mm_active = |(ACTIVE_FUNCTIONS & sosc_pkg::motion_mask(brake_mon));
  logic [31:0] status_word;
  logic [31:0] read_mux;
  always_comb
  begin
    status_word = '0;
    status_word[sosc_pkg::ST_STATE_LSB +: 3] = state;
    status_word[sosc_pkg::ST_SUB_LSB +: 2] = sub;
    status_word[sosc_pkg::ST_CFG_VALID_BIT] = cfg_valid;
    status_word[sosc_pkg::ST_IN_FAULT_BIT] = sio.in_fault;
    status_word[sosc_pkg::ST_OUT_FAULT_BIT] = sio.out_fault;
    status_word[sosc_pkg::ST_CFG_REQ_BIT] = cfg_req;
    status_word[sosc_pkg::ST_MM_BIT] = mm_active;
    status_word[sosc_pkg::ST_IN_LEVEL_LSB +: N_IN] = sio.in_level;
  end

  assign read_mux = hit_ctrl ? {27'h0000000, brake_mon, 4'h0} :
    hit_delay ? {{(32 - DW){1'b0}}, halt_delay} :
    hit_outcmd ? {{(32 - N_OUT){1'b0}}, out_cmd} :
    hit_status ? status_word : 32'h00000000;

  assign PREADY = 1'b1;
  assign PSLVERR = access & ~addr_hit;

  // ----------------------------------------------------------------
  // transition causes
  // ----------------------------------------------------------------
  // activation inputs request when the agreed level is low
  wire ramped_halt_request_input = ~sio.in_level[sosc_pkg::IN_RAMPED_HALT];
  wire torque_off_request_input = ~sio.in_level[sosc_pkg::IN_TORQUE_OFF];
  wire fatal_cause = FATAL_ERROR;
  wire fault_cause = LIMIT_VIOLATION | SELF_TEST_FAULT | sio.in_fault | sio.out_fault;
  wire stop_cause = ramped_halt_request_input;
  wire delay_done = (halt_left == '0);
  wire restart_ok = ~fatal_cause & ~stop_cause & ~torque_off_request_input;

  // ----------------------------------------------------------------
  // operating state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_sub = sub;
    case (state)
      sosc_pkg::POWER_ON_ST:
      begin
        next_state = sosc_pkg::TORQUE_OFF_ST;
      end
      sosc_pkg::TORQUE_OFF_ST:
      begin
        if (cfg_req)
          next_state = sosc_pkg::CONFIG_ST;
        else if (boot_pending)
          next_state = sosc_pkg::STARTUP_ST;
        else if (reset_action && restart_ok)
          next_state = sosc_pkg::STARTUP_ST;
      end
      sosc_pkg::STARTUP_ST:
      begin
        if (fatal_cause)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_FATAL;
        end
        else if (startup_begun && (fault_cause || !cfg_valid))
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_FAULT;
        end
        else if (startup_begun && SELF_TEST_DONE)
          next_state = sosc_pkg::RUN_ST;
      end
      sosc_pkg::RUN_ST, sosc_pkg::MONITORED_RUN_ST:
      begin
        if (fatal_cause)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_FATAL;
        end
        else if (fault_cause)
        begin
          next_state = sosc_pkg::RAMPED_HALT_ST;
          next_sub = sosc_pkg::SUB_FAULT;
        end
        else if (torque_off_request_input)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_STOP;
        end
        else if (stop_cause || cfg_req)
        begin
          next_state = sosc_pkg::RAMPED_HALT_ST;
          next_sub = stop_cause ? sosc_pkg::SUB_STOP : sosc_pkg::SUB_NONE;
        end
        else if (mm_active)
          next_state = sosc_pkg::MONITORED_RUN_ST;
        else
          next_state = sosc_pkg::RUN_ST;
      end
      sosc_pkg::RAMPED_HALT_ST:
      begin
        if (fatal_cause)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_FATAL;
        end
        else if (brake_mon && BRAKE_RAMP_EXCEEDED)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          if (sub != sosc_pkg::SUB_FAULT)
            next_sub = sosc_pkg::SUB_FAULT;
        end
        else if (torque_off_request_input && sub != sosc_pkg::SUB_FAULT)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_STOP;
        end
        else if (delay_done)
          next_state = sosc_pkg::TORQUE_OFF_ST;
      end
      sosc_pkg::CONFIG_ST:
      begin
        if (cfg_bad)
        begin
          next_state = sosc_pkg::TORQUE_OFF_ST;
          next_sub = sosc_pkg::SUB_FAULT;
        end
        else if (cfg_ok)
          next_state = sosc_pkg::STARTUP_ST;
      end
      default:
      begin
        next_state = sosc_pkg::TORQUE_OFF_ST;
        next_sub = sosc_pkg::SUB_FATAL;
      end
    endcase
    if (next_state == sosc_pkg::STARTUP_ST && state != sosc_pkg::STARTUP_ST)
      next_sub = sosc_pkg::SUB_NONE;
  end

  wire enter_startup = (next_state == sosc_pkg::STARTUP_ST) && (state != sosc_pkg::STARTUP_ST);
  wire enter_halt = (next_state == sosc_pkg::RAMPED_HALT_ST) &&
    (state != sosc_pkg::RAMPED_HALT_ST);
  wire next_torque_off = !sosc_pkg::is_running(next_state) &&
    (next_state != sosc_pkg::RAMPED_HALT_ST);
  assign sio.clear = enter_startup;
  assign sio.out_cmd = sosc_pkg::is_running(state) ? out_cmd : '0;

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      state <= sosc_pkg::POWER_ON_ST;
      sub <= sosc_pkg::SUB_NONE;
      TORQUE_OFF <= 1'b1;
      RAMPED_HALT_ACTIVE <= 1'b0;
      SELF_TEST_START <= 1'b0;
      startup_begun <= 1'b0;
    end
    else
    begin
      state <= next_state;
      sub <= next_sub;
      TORQUE_OFF <= next_torque_off;
      RAMPED_HALT_ACTIVE <= (next_state == sosc_pkg::RAMPED_HALT_ST);
      SELF_TEST_START <= enter_startup;
      startup_begun <= (state == sosc_pkg::STARTUP_ST);
    end
  end

  assign OP_STATE = state;
  assign SUB_STATUS = sub;

  // ----------------------------------------------------------------
  // boot, configuration and halt timing
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      boot_pending <= 1'b1;
      cfg_valid <= 1'b0;
      cfg_req <= 1'b0;
      halt_left <= '0;
      us_cnt <= '0;
    end
    else
    begin
      if (enter_startup)
        boot_pending <= 1'b0;
      if (state == sosc_pkg::POWER_ON_ST)
        cfg_valid <= CFG_PRESENT;
      else if (state == sosc_pkg::CONFIG_ST && (cfg_ok || cfg_bad))
        cfg_valid <= cfg_ok & ~cfg_bad;
      // set wins over clear
      cfg_req <= cfg_req_set | (cfg_req & (state != sosc_pkg::CONFIG_ST));
      if (enter_halt)
      begin
        halt_left <= halt_delay;
        us_cnt <= '0;
      end
      else if (state == sosc_pkg::RAMPED_HALT_ST && !delay_done)
      begin
        us_cnt <= (us_cnt == US_END) ? '0 : us_cnt + PSW'(1);
        if (us_cnt == US_END)
          halt_left <= halt_left - DW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // bus registers
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      brake_mon <= sosc_pkg::BRAKE_MON_RST;
      halt_delay <= sosc_pkg::DELAY_RST;
      out_cmd <= '0;
      PRDATA <= '0;
    end
    else
    begin
      if (wr_ctrl)
        brake_mon <= PWDATA[sosc_pkg::CTRL_BRAKE_MON_BIT];
      if (wr_ok && hit_delay)
        halt_delay <= PWDATA[DW-1:0];
      if (wr_ok && hit_outcmd)
        out_cmd <= PWDATA[N_OUT-1:0];
      if (PSEL && !PENABLE && !PWRITE)
        PRDATA <= read_mux;
    end
  end

endmodule : safety_operating_state_controller

/* sosc_checker.sv */
`timescale 1ns/100ps
module sosc_checker (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [2:0] OP_STATE,
  input wire logic [1:0] SUB_STATUS,
  input wire logic TORQUE_OFF,
  input wire logic RAMPED_HALT_ACTIVE,
  input wire logic SELF_TEST_START,
  input wire logic FATAL_ERROR,
  input wire logic LIMIT_VIOLATION,
  input wire logic [sosc_pkg::SF_COUNT-1:0] ACTIVE_FUNCTIONS
);
  // ------------------------------
  // state sequencing checks
  // ------------------------------
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (RST);
  wire running = OP_STATE == 3'h3 || OP_STATE == 3'h4;
  sequence enter_startup;
    OP_STATE == 3'h2 && $past(OP_STATE) != 3'h2;
  endsequence
  sequence enter_monitored;
    OP_STATE == 3'h4 && $past(OP_STATE) == 3'h3;
  endsequence
  chk_state_legal: assert property (OP_STATE <= 3'h6)
    else $error("state code out of range");
  chk_power_exit: assert property (!RST && OP_STATE == 3'h0 |=> OP_STATE == 3'h1)
    else $error("power-on not left for torque-off");
  chk_test_kick: assert property (enter_startup |-> ##[0:1] SELF_TEST_START)
    else $error("self-test not started");
  chk_torque_free: assert property (OP_STATE inside {0, 1, 2, 6} |-> TORQUE_OFF)
    else $error("torque not off");
  chk_halt_flag: assert property (RAMPED_HALT_ACTIVE == (OP_STATE == 3'h5))
    else $error("halt flag wrong");
  chk_fatal_cut: assert property (FATAL_ERROR && (running || OP_STATE == 3'h5)
    |=> OP_STATE == 3'h1 && SUB_STATUS == 2'h3) else $error("fatal not cut");
  chk_fault_halt: assert property (LIMIT_VIOLATION && !FATAL_ERROR && running
    |=> OP_STATE == 3'h5 && SUB_STATUS == 2'h2) else $error("fault not halted");
  chk_monitor_cause: assert property (enter_monitored
    |-> $past(ACTIVE_FUNCTIONS[15:4] != 0 || ACTIVE_FUNCTIONS[3])) else $error("no cause");
endmodule : sosc_checker
bind safety_operating_state_controller sosc_checker sosc_checker_inst (.REF_CLK, .RST,
  .OP_STATE, .SUB_STATUS, .TORQUE_OFF, .RAMPED_HALT_ACTIVE, .SELF_TEST_START, .FATAL_ERROR,
  .LIMIT_VIOLATION, .ACTIVE_FUNCTIONS);

/* sosc_drive_model.sv */
`timescale 1ns/100ps
module sosc_drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic fail,
  input wire logic stuck,
  input wire logic [1:0] safe_out,
  output logic done,
  output logic fault,
  output logic [1:0] readback
);
  logic [2:0] cnt;
  always_ff @(posedge clk)
  begin
    if (rst)
      cnt <= 3'h0;
    else if (start)
      cnt <= 3'h5;
    else if (cnt != 3'h0)
      cnt <= cnt - 3'h1;
  end
  assign done = cnt == 3'h1;
  assign fault = fail && cnt != 3'h0;
  // outputs follow command
  // a stuck-high readback makes the outputs look unswitchable
  assign readback = safe_out | {2{stuck}};
endmodule : sosc_drive_model

/* sosc_pkg.sv */
package sosc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 200;
  localparam int DISC_TIME_US = 10;
  localparam int DISC_CYCLES = DISC_TIME_US * CLK_MHZ;
  localparam int TEST_PERIOD_US = 100;
  localparam int TEST_PERIOD_CYCLES = TEST_PERIOD_US * CLK_MHZ;
  localparam int TEST_WIDTH_US = 1;
  localparam int TEST_WIDTH_CYCLES = TEST_WIDTH_US * CLK_MHZ;
  localparam int SETTLE_NS = 500;
  localparam int SETTLE_CYCLES = (SETTLE_NS * CLK_MHZ) / 1000;
  localparam int US_CYCLES = CLK_MHZ;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] DELAY_OFS = 12'h004;
  localparam logic [11:0] OUTCMD_OFS = 12'h008;
  localparam logic [11:0] STATUS_OFS = 12'h00c;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_CFG_REQ_BIT = 1;
  localparam int CTRL_CFG_OK_BIT = 2;
  localparam int CTRL_CFG_BAD_BIT = 3;
  localparam int CTRL_BRAKE_MON_BIT = 4;
  localparam int DELAY_W = 20;
  localparam logic [19:0] DELAY_RST = 20'h003e8;
  localparam logic BRAKE_MON_RST = 1'b0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_SUB_LSB = 4;
  localparam int ST_CFG_VALID_BIT = 8;
  localparam int ST_IN_FAULT_BIT = 9;
  localparam int ST_OUT_FAULT_BIT = 10;
  localparam int ST_CFG_REQ_BIT = 11;
  localparam int ST_MM_BIT = 12;
  localparam int ST_IN_LEVEL_LSB = 16;

  // ----------------------------------------------------------------
  // safety functions and safe inputs
  // ----------------------------------------------------------------
  localparam int SF_COUNT = 16;
  localparam int SF_OPERATIONAL_HALT = 0;
  localparam int SF_BRAKE_CONTROL = 1;
  localparam int SF_RESTART_LOCK = 2;
  localparam int SF_RAMPED_HALT = 3;
  localparam int IN_RAMPED_HALT = 0;
  localparam int IN_TORQUE_OFF = 1;

  typedef enum logic [2:0] {
    POWER_ON_ST = 3'b000,
    TORQUE_OFF_ST = 3'b001,
    STARTUP_ST = 3'b010,
    RUN_ST = 3'b011,
    MONITORED_RUN_ST = 3'b100,
    RAMPED_HALT_ST = 3'b101,
    CONFIG_ST = 3'b110
  } op_state_e;

  typedef enum logic [1:0] {
    SUB_NONE = 2'b00,
    SUB_STOP = 2'b01,
    SUB_FAULT = 2'b10,
    SUB_FATAL = 2'b11
  } sub_status_e;

  // functions that keep the motor moving under supervision
  function automatic logic [SF_COUNT-1:0] motion_mask(input logic brake_mon);
    logic [SF_COUNT-1:0] m;
    m = '1;
    m[SF_OPERATIONAL_HALT] = 1'b0;
    m[SF_BRAKE_CONTROL] = 1'b0;
    m[SF_RESTART_LOCK] = 1'b0;
    m[SF_RAMPED_HALT] = brake_mon;
    return m;
  endfunction : motion_mask

  function automatic logic is_running(input op_state_e s);
    return (s == RUN_ST) || (s == MONITORED_RUN_ST);
  endfunction : is_running

endpackage : sosc_pkg

/* test_safety_operating_state_controller.sv */
`timescale 1ns/100ps
module test_safety_operating_state_controller;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, fatal = 0, limit = 0, fail = 0;
  logic br = 0, stuck = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, rv;
  logic [3:0] sin = 4'hf;
  logic [15:0] af = 0;
  logic [15:0] corner [5] = '{16'h000f, 16'h0010, 16'h0008, 16'h0000, 16'h0004};
  logic [1:0] sout, rb, sub;
  logic [2:0] st;
  logic pready, pslverr, err, sts, std, stf, toff;
  int error_cnt = 0, n_tests = 0, cyc = 0, k, j;
  always #2.5 clk = ~clk;
  safety_operating_state_controller #(.TEST_PERIOD_CYCLES(400))
    safety_operating_state_controller_inst (.REF_CLK(clk), .RST(rst), .PSEL(psel),
    .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .SAFE_IN_A(sin), .SAFE_IN_B(sin), .SAFE_OUT(sout),
    .SAFE_OUT_READBACK(rb), .ACTIVE_FUNCTIONS(af), .LIMIT_VIOLATION(limit),
    .FATAL_ERROR(fatal), .BRAKE_RAMP_EXCEEDED(br), .CFG_PRESENT(1'b1),
    .SELF_TEST_START(sts), .SELF_TEST_DONE(std), .SELF_TEST_FAULT(stf), .TORQUE_OFF(toff),
    .RAMPED_HALT_ACTIVE(), .OP_STATE(st), .SUB_STATUS(sub));
  sosc_drive_model sosc_drive_model_inst (.clk(clk), .rst(rst), .start(sts), .fail(fail),
    .stuck(stuck), .safe_out(sout), .done(std), .fault(stf), .readback(rb));
  // ------------------------------
  // tasks
  // ------------------------------
  task close_out;
    $display("tests %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pen, pwr, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    {psel, pen} <= 2'b00;
  endtask : apb
  task wst(input logic [2:0] s, input int n);
    for (k = 0; k < n && st !== s; k++)
      @(posedge clk);
    chk("state", s, st);
  endtask : wst
  task go(input logic [31:0] c, input logic [2:0] s);
    apb(1'b1, 12'h000, c);
    wst(s, 400);
  endtask : go
  function automatic logic mm(input logic [15:0] f, input logic bm);
    return |(f & {12'hfff, bm, 3'h0});
  endfunction : mm
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      close_out;
    end
  end
  initial
  begin
    void'($urandom(32'hc2ae337a));
    repeat (5) @(posedge clk);
    chk("reset", 0, st);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    chk("boot1", 1, st);
    @(posedge clk);
    chk("boot2", 2, st);
    wst(3, 200);
    apb(1'b0, 12'h004, 0);
    chk("delay rst", 32'h3e8, rd);
    apb(1'b1, 12'h004, 1);
    apb(1'b0, 12'h004, 0);
    chk("delay", 1, rd);
    apb(1'b0, 12'h010, 0);
    chk("slverr", 1, err);
    for (j = 0; j < 3; j++)
    begin
      rv = $urandom;
      apb(1'b1, 12'h008, rv);
      apb(1'b0, 12'h008, 0);
      chk("outcmd", rv & 3, rd);
    end
    for (j = 0; j < 9; j++)
    begin
      af <= (j < 5) ? corner[j] : 16'($urandom);
      repeat (3) @(posedge clk);
      chk("monitor", mm(af, 1'b0) ? 4 : 3, st);
    end
    apb(1'b1, 12'h000, 32'h10);
    af <= 16'h0008;
    repeat (3) @(posedge clk);
    chk("brake mon", 4, st);
    sin <= 4'he;
    wst(5, 50);
    chk("stop sub", 1, sub);
    wst(1, 400);
    chk("halt time", 1, k >= 198 && k <= 203);
    chk("safe off", 0, sout);
    sin <= 4'hf;
    af <= 0;
    repeat (20) @(posedge clk);
    go(1, 3);
    chk("sub clr", 0, sub);
    {fatal, limit} <= 2'b11;
    wst(1, 5);
    chk("fatal sub", 3, sub);
    {fatal, limit} <= 2'b00;
    go(1, 3);
    limit <= 1'b1;
    wst(5, 5);
    chk("fault sub", 2, sub);
    limit <= 1'b0;
    wst(1, 400);
    fail <= 1'b1;
    go(1, 2);
    wst(1, 50);
    fail <= 1'b0;
    go(1, 3);
    stuck <= 1'b1;
    wst(5, 500);
    chk("out fault sub", 2, sub);
    stuck <= 1'b0;
    wst(1, 400);
    go(32'h11, 3);
    sin <= 4'he;
    wst(5, 50);
    br <= 1'b1;
    wst(1, 3);
    chk("brake sub", 2, sub);
    {br, sin} <= {1'b0, 4'hf};
    go(1, 3);
    sin <= 4'hd;
    wst(1, 5);
    chk("off sub", 1, sub);
    sin <= 4'hf;
    go(1, 3);
    go(2, 5);
    wst(6, 400);
    chk("cfg torque", 1, toff);
    go(4, 2);
    wst(3, 100);
    go(2, 5);
    wst(6, 400);
    go(8, 1);
    close_out;
  end
endmodule : test_safety_operating_state_controller
